/* File: pkg/tsi_map.vh */
/*
  Register map, field positions, reset values and encodings of the
  touch sensor interrupt logic.
  Assumes it is included by bare name from the design files.
*/
`ifndef TSI_MAP_VH
`define TSI_MAP_VH

// Register offsets on the internal register port
`define TSI_ADDR_W 10
`define TSI_A_BELOW_EN 10'h005
`define TSI_A_ABOVE_EN 10'h006
`define TSI_A_DONE_EN 10'h007
`define TSI_A_BELOW_FLG 10'h008
`define TSI_A_ABOVE_FLG 10'h009
`define TSI_A_DONE_FLG 10'h00a

// Data width and reset values
`define TSI_DATA_W 16
`define TSI_RST_16 16'h0000
`define TSI_STAGES 12

// Pin interrupt enable and pin status bit (in 0x007 and 0x00a)
`define TSI_PIN_BIT 12
// Pin direction select and trigger select fields (in 0x005)
`define TSI_DIR_LSB 12
`define TSI_DIR_MSB 13
`define TSI_TRG_LSB 14
`define TSI_TRG_MSB 15

// Pin direction select codes
`define TSI_DIR_INPUT 2'b01
// Pin trigger select codes
`define TSI_TRG_LOW 2'b00
`define TSI_TRG_RISE 2'b01
`define TSI_TRG_FALL 2'b10
`define TSI_TRG_HIGH 2'b11

`endif

/* File: hdl/tsi_pin_trig.v */
/*
  Auxiliary pin trigger: two-stage synchroniser, then level or edge
  detection as chosen by the trigger select.
  Assumes the pin is asynchronous to clk_i; the caller gates by direction.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tsi_map.vh"

module tsi_pin_trig
(
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Configuration
  input wire [1:0] trg_sel_i,
  // Pin
  input wire pin_i,
  // Results
  output reg trig_o,
  output reg active_o
);

  reg meta_r;
  reg sync_r;
  reg prev_r;
  reg trig_nxt;
  reg active_nxt;

  ////////////////////////////////////////////////////////////////////
  // Synchroniser; meta_r feeds sync_r only
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end
    else
    begin
      meta_r <= pin_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Trigger decode; active means the cause still stands
  always @*
  begin
    trig_nxt = 1'b0;
    active_nxt = 1'b0;
    case (trg_sel_i)
      `TSI_TRG_LOW:
      begin
        trig_nxt = ~sync_r;
        active_nxt = ~sync_r;
      end
      `TSI_TRG_RISE:
        trig_nxt = sync_r & ~prev_r;
      `TSI_TRG_FALL:
        trig_nxt = ~sync_r & prev_r;
      `TSI_TRG_HIGH:
      begin
        trig_nxt = sync_r;
        active_nxt = sync_r;
      end
      default:
        trig_nxt = 1'b0;
    endcase
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      trig_o <= 1'b0;
      active_o <= 1'b0;
    end
    else
    begin
      trig_o <= trig_nxt;
      active_o <= active_nxt;
    end
  end

endmodule // tsi_pin_trig
`default_nettype wire

/* File: hdl/tsi_irq.v */
/*
  Interrupt logic of a capacitance touch controller: stage-done,
  threshold and auxiliary pin sources, enable and status registers,
  active-low open-drain alert.
  Assumes a serial interface front end that presents a register port
  (address, write strobe, read-setup strobe) on clk_i, and a converter
  that pulses stage completion and presents per-stage limit levels.
*/
// Function
// - Alert is active-low open drain: pull low when asserted, release otherwise.
// - Three sources, stage done, threshold and pin, each with enable and status.
// - Stage-done and threshold interrupts enable separately per stage.
// - Host read clears status and releases alert once read address is set up.
// - Enabled stage completing with result stored pulls alert low.
// - Stage-done enable register at 0x007, one bit per stage.
// - Stage-done status at 0x00A, bit set when that stage triggered.
// - Reading 0x00A clears bits unless their cause still persists.
// - Touch mode alerts once on contact start and again on contact end.
// - Threshold enables per stage at 0x005 and 0x006.
// - Threshold status readable at 0x008 and 0x009.
// - Threshold alert stays low until host reads threshold status.
// - Any change of enabled threshold status bits raises the alert.
// - Threshold status shows currently activated stages at read time.
// - Low-limit crossing on enabled stage sets status and alerts; untouched stages not.
// - Pin interrupt enable bit lives in 0x007.
// - Pin status bit in 0x00A, same read-to-clear behaviour.
// - Pin trigger select: 00 low, 01 rise, 10 fall, 11 high.
// - Pin is a source only when direction select is 01.
`timescale 1ns/1ps
`default_nettype none
`include "tsi_map.vh"

module tsi_irq
#(
  parameter NSTG = `TSI_STAGES
)
(
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Register port from the serial front end
  input wire [`TSI_ADDR_W-1:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [`TSI_DATA_W-1:0] reg_wdata_i,
  input wire reg_rd_i,
  output reg [`TSI_DATA_W-1:0] reg_rdata_o,
  // Converter events
  input wire [NSTG-1:0] stage_done_i,
  input wire [NSTG-1:0] below_lim_i,
  input wire [NSTG-1:0] above_lim_i,
  // Auxiliary pin
  input wire aux_pin_i,
  // Open-drain alert pin
  output reg alert_o,
  output reg alert_oe_n_o
);

  // Software registers
  reg [`TSI_DATA_W-1:0] below_en_r;
  reg [`TSI_DATA_W-1:0] above_en_r;
  reg [`TSI_DATA_W-1:0] done_en_r;
  reg [NSTG-1:0] done_flg_r;
  reg [NSTG-1:0] done_flg_nxt;
  reg pin_flg_r;
  reg pin_flg_nxt;
  // Threshold tracking
  reg [NSTG-1:0] below_now_r;
  reg [NSTG-1:0] above_now_r;
  reg [NSTG-1:0] below_seen_r;
  reg [NSTG-1:0] above_seen_r;
  reg thr_evt_r;
  reg thr_evt_nxt;
  reg pend_nxt;
  reg [`TSI_DATA_W-1:0] rdata_nxt;
  // Per-stage and pin terms after gating by their enables
  wire [NSTG-1:0] done_set;
  wire [NSTG-1:0] below_act;
  wire [NSTG-1:0] above_act;
  wire pin_set;
  wire pin_hold;
  // Decoded accesses
  wire rd_below;
  wire rd_above;
  wire rd_done;
  wire thr_chg;
  wire pin_src;
  wire pin_trig;
  wire pin_active;
  wire [NSTG-1:0] below_en;
  wire [NSTG-1:0] above_en;
  wire [NSTG-1:0] done_en;

  ////////////////////////////////////////////////////////////////////
  // Field slices; bit n is stage n
  assign below_en = below_en_r[NSTG-1:0];
  assign above_en = above_en_r[NSTG-1:0];
  assign done_en = done_en_r[NSTG-1:0];

  // Read strobes act at address setup, ahead of the data phase
  assign rd_below = reg_rd_i && (reg_addr_i == `TSI_A_BELOW_FLG);
  assign rd_above = reg_rd_i && (reg_addr_i == `TSI_A_ABOVE_FLG);
  assign rd_done = reg_rd_i && (reg_addr_i == `TSI_A_DONE_FLG);

  ////////////////////////////////////////////////////////////////////
  // Per-stage gating by the enable bits; each stage is masked in one
  // place only, so the flags and the live levels cannot disagree
  genvar g;
  generate
    for (g = 0; g < NSTG; g = g + 1)
    begin : g_stage
      assign done_set[g] = stage_done_i[g] & done_en[g];
      assign below_act[g] = below_lim_i[g] & below_en[g];
      assign above_act[g] = above_lim_i[g] & above_en[g];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Auxiliary pin trigger; only a source when set as input
  assign pin_src = (below_en_r[`TSI_DIR_MSB:`TSI_DIR_LSB] == `TSI_DIR_INPUT);

  tsi_pin_trig u_pin
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .trg_sel_i(below_en_r[`TSI_TRG_MSB:`TSI_TRG_LSB]),
    .pin_i(aux_pin_i),
    .trig_o(pin_trig),
    .active_o(pin_active)
  );

  // Pin terms; a standing level keeps its flag over a read
  assign pin_set = pin_trig & pin_src & done_en_r[`TSI_PIN_BIT];
  assign pin_hold = pin_active & pin_src & done_en_r[`TSI_PIN_BIT];

  ////////////////////////////////////////////////////////////////////
  // Enable registers, written by the host
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      below_en_r <= `TSI_RST_16;
      above_en_r <= `TSI_RST_16;
      done_en_r <= `TSI_RST_16;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == `TSI_A_BELOW_EN)
        below_en_r <= reg_wdata_i;
      if (reg_addr_i == `TSI_A_ABOVE_EN)
        above_en_r <= reg_wdata_i;
      if (reg_addr_i == `TSI_A_DONE_EN)
        done_en_r <= reg_wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Stage-done and pin status; a set in the read cycle wins the clear
  always @*
  begin
    done_flg_nxt = done_flg_r;
    pin_flg_nxt = pin_flg_r;
    if (rd_done)
    begin
      done_flg_nxt = {NSTG{1'b0}};
      pin_flg_nxt = pin_flg_r & pin_hold;
    end
    done_flg_nxt = done_flg_nxt | done_set;
    if (pin_set)
      pin_flg_nxt = 1'b1;
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      done_flg_r <= {NSTG{1'b0}};
      pin_flg_r <= 1'b0;
    end
    else
    begin
      done_flg_r <= done_flg_nxt;
      pin_flg_r <= pin_flg_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Threshold sources: live activation levels, event on any change
  // Levels are same-clock logic from the converter, so no sync here
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      below_now_r <= {NSTG{1'b0}};
      above_now_r <= {NSTG{1'b0}};
      below_seen_r <= {NSTG{1'b0}};
      above_seen_r <= {NSTG{1'b0}};
    end
    else
    begin
      below_now_r <= below_act;
      above_now_r <= above_act;
      below_seen_r <= below_now_r;
      above_seen_r <= above_now_r;
    end
  end

  // Touch start, set change and release all count as change
  assign thr_chg = (below_now_r != below_seen_r) ||
                   (above_now_r != above_seen_r);

  always @*
  begin
    thr_evt_nxt = thr_evt_r;
    if (rd_below || rd_above)
      thr_evt_nxt = 1'b0;
    if (thr_chg)
      thr_evt_nxt = 1'b1;
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
      thr_evt_r <= 1'b0;
    else
      thr_evt_r <= thr_evt_nxt;
  end

  ////////////////////////////////////////////////////////////////////
  // Alert: low while any enabled status is pending
  always @*
  begin
    pend_nxt = (|done_flg_nxt) | pin_flg_nxt | thr_evt_nxt;
  end

  // Open drain: the driven level is always low, only enable moves
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      alert_o <= 1'b0;
      alert_oe_n_o <= 1'b1;
    end
    else
    begin
      alert_o <= 1'b0;
      alert_oe_n_o <= ~pend_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read mux; flag words show the state before this read clears it
  always @*
  begin
    rdata_nxt = `TSI_RST_16;
    case (reg_addr_i)
      `TSI_A_BELOW_EN:
        rdata_nxt = below_en_r;
      `TSI_A_ABOVE_EN:
        rdata_nxt = above_en_r;
      `TSI_A_DONE_EN:
        rdata_nxt = done_en_r;
      `TSI_A_BELOW_FLG:
        rdata_nxt[NSTG-1:0] = below_now_r;
      `TSI_A_ABOVE_FLG:
        rdata_nxt[NSTG-1:0] = above_now_r;
      `TSI_A_DONE_FLG:
      begin
        rdata_nxt[NSTG-1:0] = done_flg_r;
        rdata_nxt[`TSI_PIN_BIT] = pin_flg_r;
      end
      default:
        rdata_nxt = `TSI_RST_16; // Unmapped words read as zero
    endcase
  end

  // Read data register, captured at address setup before the clear
  // lands; it holds until the next read strobe
  always @(posedge clk_i)
  begin
    if (rst_i)
      reg_rdata_o <= `TSI_RST_16;
    else if (reg_rd_i)
      reg_rdata_o <= rdata_nxt;
  end

endmodule // tsi_irq
`default_nettype wire

/* File: bench/tsi_irq_sva.sv */
/* Port checker for tsi_irq.
   Assumes a bind onto tsi_irq; shadows the below and done enables from port writes. */
`timescale 1ns/1ps
`default_nettype none
`include "tsi_map.vh"
module tsi_irq_sva #(parameter NSTG = 12)
(
  // Clock, reset and register port
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [9:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  // Events and alert pin
  input wire logic [NSTG-1:0] stage_done_i,
  input wire logic [NSTG-1:0] below_lim_i,
  input wire logic [NSTG-1:0] above_lim_i,
  input wire logic aux_pin_i,
  input wire logic alert_o,
  input wire logic alert_oe_n_o
);
  logic [15:0] ben_r;
  logic [15:0] den_r;
  wire logic [NSTG-1:0] mk = below_lim_i & ben_r[NSTG-1:0];
  ////////////////////////////////////////
  // Shadow enables, so event checks know what is armed
  always @(posedge clk_i)
    if (rst_i)
    begin
      ben_r <= 16'h0000;
      den_r <= 16'h0000;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == `TSI_A_BELOW_EN) ben_r <= reg_wdata_i;
      if (reg_addr_i == `TSI_A_DONE_EN) den_r <= reg_wdata_i;
    end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_drain_only: assert property (alert_o == 1'b0)
    else $error("alert data not low");
  a_done_alert: assert property ((stage_done_i & den_r[NSTG-1:0]) != 0 |=> !alert_oe_n_o)
    else $error("done event without alert");
  a_alert_held: assert property (!alert_oe_n_o && !reg_rd_i && !reg_wr_i |=> !alert_oe_n_o)
    else $error("alert released without read");
  a_thr_change: assert property (!$past(rst_i) && mk != $past(mk) && $stable(ben_r)
    |-> ##2 !alert_oe_n_o)
    else $error("threshold change without alert");
  a_live_below: assert property (reg_rd_i && reg_addr_i == `TSI_A_BELOW_FLG && $stable(mk)
    |=> reg_rdata_o[NSTG-1:0] == $past(mk))
    else $error("below status not live");
  a_done_readback: assert property (reg_rd_i && reg_addr_i == `TSI_A_DONE_EN
    |=> reg_rdata_o[12:0] == $past(den_r[12:0]))
    else $error("done enable readback");
  a_read_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved");
  a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> alert_oe_n_o
    && reg_rdata_o == 16'h0000)
    else $error("reset state wrong");
  c_done: cover property (stage_done_i != 0 ##1 !alert_oe_n_o);
  c_below: cover property (reg_rd_i && reg_addr_i == `TSI_A_BELOW_FLG ##1 reg_rdata_o != 0);
  c_pin: cover property (reg_rd_i && reg_addr_i == `TSI_A_DONE_FLG ##1 reg_rdata_o[12]);
endmodule // tsi_irq_sva
`default_nettype wire

/* File: bench/tsi_host.sv */
/* Host side of the alert line: a pull-up resistor.
   Assumes the open-drain pair of tsi_irq. */
`timescale 1ns/1ps
`default_nettype none
module tsi_host
(
  // Open-drain pair in, resolved line out
  input wire logic alert_o,
  input wire logic alert_oe_n_o,
  output wire logic int_n_o
);
  // Pull-up wins unless the device drives low
  assign int_n_o = alert_oe_n_o ? 1'b1 : alert_o;
endmodule // tsi_host
`default_nettype wire

/* File: bench/tsi_irq_tb.sv */
/* Self-checking bench for tsi_irq.
   Assumes tsi_irq_sva and tsi_host are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
  $display("ERROR %0t got %h want %h", $time, a, b); end end
module tsi_irq_tb;
  logic clk_i = 0;
  logic rst_i = 1;
  logic [9:0] reg_addr_i = 0;
  logic reg_wr_i = 0;
  logic reg_rd_i = 0;
  logic [15:0] reg_wdata_i = 0;
  logic [11:0] stage_done_i = 0;
  logic [11:0] below_lim_i = 0;
  logic [11:0] above_lim_i = 0;
  logic aux_pin_i = 0;
  wire logic [15:0] reg_rdata_o;
  wire logic alert_o;
  wire logic alert_oe_n_o;
  wire logic int_n;
  logic [15:0] ben, aen, den;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int n, m;
  int modes[$] = '{0, 1, 2, 3};
  ////////////////////////////////////////
  tsi_irq #(.NSTG(12)) tsi_irq_i (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .stage_done_i(stage_done_i), .below_lim_i(below_lim_i),
    .above_lim_i(above_lim_i), .aux_pin_i(aux_pin_i), .alert_o(alert_o),
    .alert_oe_n_o(alert_oe_n_o));
  tsi_host tsi_host_i (.alert_o(alert_o), .alert_oe_n_o(alert_oe_n_o), .int_n_o(int_n));
  always #5 clk_i = ~clk_i;
  // Register port cycles, one strobe each, driven on falling edges
  task wr(input logic [9:0] a, input logic [15:0] d);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1;
    @(negedge clk_i);
    reg_wr_i = 0;
  endtask
  task rd(input logic [9:0] a, input logic [15:0] e);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_rd_i = 1;
    @(negedge clk_i);
    reg_rd_i = 0;
    `CHK(reg_rdata_o, e)
  endtask
  task idle(input int c);
    repeat (c) @(negedge clk_i);
  endtask
  task conclude;
    if (errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles needed
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errors++;
      conclude;
    end
  end
  // Main sequence
  initial
  begin
    void'($urandom(32'h6729));
    repeat (5) @(negedge clk_i);
    rst_i = 0;
    for (int a = 5; a < 12; a++) rd(a[9:0], 16'h0000);
    n = $urandom % 12;
    m = (n + 5) % 12;
    ben = ($urandom | (1 << n)) & 16'h0fff;
    aen = $urandom & 16'h0fff;
    den = ($urandom | (1 << n)) & ~(1 << m) & 16'h0fff;
    wr(5, ben);
    wr(6, aen);
    wr(7, den);
    rd(5, ben);
    rd(6, aen);
    rd(7, den);
    // Disabled stage is ignored, enabled one alerts
    stage_done_i = 1 << m;
    idle(1);
    stage_done_i = 0;
    idle(2);
    `CHK(int_n, 1'b1)
    stage_done_i = 1 << n;
    idle(1);
    stage_done_i = 0;
    idle(2);
    `CHK(int_n, 1'b0)
    rd(10, 16'h0001 << n);
    idle(1);
    `CHK(int_n, 1'b1)
    rd(10, 16'h0000);
    // Host arms only the last stage of a 0..n sequence
    wr(7, 16'h0001 << n);
    for (int s = 0; s < n; s++)
    begin
      stage_done_i = 12'h001 << s;
      idle(1);
    end
    stage_done_i = 0;
    idle(2);
    `CHK(int_n, 1'b1)
    stage_done_i = 12'h001 << n;
    idle(1);
    stage_done_i = 0;
    idle(2);
    `CHK(int_n, 1'b0)
    rd(10, 16'h0001 << n);
    wr(7, den);
    // Touch, then lift off
    below_lim_i = $urandom;
    below_lim_i[n] = 1;
    above_lim_i = $urandom;
    idle(4);
    `CHK(int_n, 1'b0)
    rd(8, {4'h0, below_lim_i} & ben);
    rd(9, {4'h0, above_lim_i} & aen);
    idle(1);
    `CHK(int_n, 1'b1)
    below_lim_i = 0;
    above_lim_i = 0;
    idle(4);
    `CHK(int_n, 1'b0)
    rd(8, 16'h0000);
    idle(1);
    `CHK(int_n, 1'b1)
    // Every pin trigger mode, pin disabled while reconfigured
    foreach (modes[i])
    begin
      wr(7, den);
      aux_pin_i = !modes[i][0];
      wr(5, {modes[i][1:0], 2'b01, ben[11:0]});
      wr(7, den | 16'h1000);
      idle(6);
      rd(10, 16'h0000);
      aux_pin_i = modes[i][0];
      idle(6);
      `CHK(int_n, 1'b0)
      rd(10, 16'h1000);
      aux_pin_i = !modes[i][0];
      idle(6);
      rd(10, (modes[i] == 0 || modes[i] == 3) ? 16'h1000 : 16'h0000);
      rd(10, 16'h0000);
      idle(1);
      `CHK(int_n, 1'b1)
    end
    // Pin not an input: no alert
    wr(5, {4'hc, ben[11:0]});
    aux_pin_i = 1;
    idle(6);
    `CHK(int_n, 1'b1)
    rd(10, 16'h0000);
    conclude;
  end
endmodule // tsi_irq_tb
bind tsi_irq tsi_irq_sva #(.NSTG(NSTG)) tsi_irq_sva_i (.clk_i(clk_i), .rst_i(rst_i),
  .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .stage_done_i(stage_done_i),
  .below_lim_i(below_lim_i), .above_lim_i(above_lim_i), .aux_pin_i(aux_pin_i),
  .alert_o(alert_o), .alert_oe_n_o(alert_oe_n_o));
`default_nettype wire
